// [core/dsg_defs.vh]
// constants for the deep-sleep clock gating control block
//
// Contract
// - each gating bit drives one unit clock enable
// - access to a gated converter or watchdog unit answers bus fault
// - deep-sleep gating register at offset 0x120
// - register is 32 bits, resets to 0x00000040
// - register supplies the deep-sleep unit enables
// - sleep registers apply only with auto gating
// - bit 16 gates converter unit, faults when gated
// - bits 9:8 select converter sample speed
// - bit 6 gates hibernation unit, no fault
// - bit 3 gates watchdog unit, faults when gated
// - reserved bits are read-only, read zero
`ifndef DSG_DEFS_VH
`define DSG_DEFS_VH

// =====================================================================
// register byte offsets, low twelve address bits
`define DSG_ADDR_DEEP      12'h120
`define DSG_ADDR_ISTAT     12'h124
`define DSG_ADDR_IMASK     12'h128
`define DSG_ADDR_MSB       11

// =====================================================================
// deep-sleep gating register layout
`define DSG_DEEP_RESET     32'h00000040
`define DSG_DEEP_WMASK     32'h00010348
`define DSG_BIT_CONV       16
`define DSG_BIT_HIB        6
`define DSG_BIT_WDOG       3
`define DSG_SPEED_MSB      9
`define DSG_SPEED_LSB      8
`define DSG_SPEED_250K     2'h1
`define DSG_SPEED_125K     2'h0

// =====================================================================
// unit indices, status and mask use the same layout
`define DSG_UNIT_CONV      0
`define DSG_UNIT_HIB       1
`define DSG_UNIT_WDOG      2
`define DSG_NUM_UNITS      3
`define DSG_FAULT_UNITS    3'h5

// =====================================================================
// power states and bus encodings
`define DSG_PWR_RUN        2'h0
`define DSG_PWR_SLEEP      2'h1
`define DSG_PWR_DEEP       2'h2
`define DSG_HSIZE_WORD     3'h2
`define DSG_HRESP_OKAY     1'b0

`endif

// [core/dsg_unit_gate.v]
// one unit's effective clock enable and gated-access fault detection
`include "dsg_defs.vh"

module dsg_unit_gate #(
   parameter CAN_FAULT = 1
) (
   input  wire       core_clk,
   input  wire       arst_n,
   input  wire       runEn,
   input  wire       sleepEn,
   input  wire       deepEn,
   input  wire       autoGatingSelect,
   input  wire [1:0] powerState,
   input  wire       unitAccess,
   output reg        clkEn_reg,
   output reg        accessFault_reg,
   output reg        gatedHit_reg
);

   reg clkEn_next;

   // =====================================================================
   // enable selection by power state
   // sleep and deep banks only count while auto gating is selected
   always @* begin
      clkEn_next = runEn;
      if (autoGatingSelect && (powerState == `DSG_PWR_SLEEP)) begin
         clkEn_next = sleepEn;
      end else if (autoGatingSelect && (powerState == `DSG_PWR_DEEP)) begin
         clkEn_next = deepEn;
      end
   end

   // =====================================================================
   // registered enable and access checks
   // the check uses the enable the unit really sees, not the next one
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         clkEn_reg       <= 1'b0;
         accessFault_reg <= 1'b0;
         gatedHit_reg    <= 1'b0;
      end else begin
         clkEn_reg       <= clkEn_next;
         gatedHit_reg    <= unitAccess & ~clkEn_reg;
         accessFault_reg <= (CAN_FAULT != 0) & unitAccess & ~clkEn_reg;
      end
   end

endmodule // dsg_unit_gate

// [core/dsg_clock_gate_ctrl.v]
// deep-sleep clock gating control: ahb-lite register slave and unit gates
`include "dsg_defs.vh"

module dsg_clock_gate_ctrl #(
   parameter NUM_UNITS = `DSG_NUM_UNITS
) (
   // clock and reset
   core_clk,
   arst_n,
   // ahb-lite slave
   hsel,
   haddr,
   htrans,
   hwrite,
   hsize,
   hwdata,
   hready,
   hrdata,
   hreadyout,
   hresp,
   // state of the power controller and the other gating banks
   runGateEn,
   sleepGateEn,
   autoGatingSelect,
   powerState,
   runSampleSpeed,
   sleepSampleSpeed,
   // unit side
   unitAccess,
   unitClkEn,
   unitFault,
   sampleSpeed,
   irq
);

   input  wire                 core_clk;
   input  wire                 arst_n;
   input  wire                 hsel;
   input  wire [31:0]          haddr;
   input  wire [1:0]           htrans;
   input  wire                 hwrite;
   input  wire [2:0]           hsize;
   input  wire [31:0]          hwdata;
   input  wire                 hready;
   output reg  [31:0]          hrdata;
   output reg                  hreadyout;
   output reg                  hresp;
   input  wire [NUM_UNITS-1:0] runGateEn;
   input  wire [NUM_UNITS-1:0] sleepGateEn;
   input  wire                 autoGatingSelect;
   input  wire [1:0]           powerState;
   input  wire [1:0]           runSampleSpeed;
   input  wire [1:0]           sleepSampleSpeed;
   input  wire [NUM_UNITS-1:0] unitAccess;
   output wire [NUM_UNITS-1:0] unitClkEn;
   output wire [NUM_UNITS-1:0] unitFault;
   output reg  [1:0]           sampleSpeed;
   output reg                  irq;

   // =====================================================================
   // bus state machine encodings
   localparam ST_IDLE = 1'b0;
   localparam ST_DATA = 1'b1;

   // =====================================================================
   // declarations
   reg                  busState_reg;
   reg                  busState_next;
   reg [`DSG_ADDR_MSB:0] addr_reg;
   reg                  isWrite_reg;
   reg                  isWord_reg;
   reg [31:0]           deepGate_reg;
   reg [31:0]           deepGate_next;
   reg [NUM_UNITS-1:0]  intStatus_reg;
   reg [NUM_UNITS-1:0]  intStatus_next;
   reg [NUM_UNITS-1:0]  intMask_reg;
   reg [NUM_UNITS-1:0]  intMask_next;
   reg [31:0]           rdData_next;
   reg [1:0]            sampleSpeed_next;
   reg [NUM_UNITS-1:0]  statusClear;
   reg [NUM_UNITS-1:0]  deepEn;
   wire                 addrPhase;
   wire                 dataWrite;
   wire                 dataRead;
   wire [NUM_UNITS-1:0] gatedHit;

   // =====================================================================
   // address phase acceptance
   // htrans bit 1 marks nonseq or seq; idle and busy are ignored
   assign addrPhase = hsel & hready & htrans[1];

   // the data phase of a captured transfer happens in ST_DATA only
   assign dataWrite = (busState_reg == ST_DATA) & isWrite_reg & isWord_reg;
   assign dataRead  = (busState_reg == ST_DATA) & ~isWrite_reg & isWord_reg;

   // =====================================================================
   // bus state machine, one wait state per transfer
   // the wait state lets hrdata come straight from a flip-flop
   always @* begin
      busState_next = busState_reg;
      case (busState_reg)
         ST_IDLE: begin
            if (addrPhase) begin
               busState_next = ST_DATA;
            end
         end
         ST_DATA: begin
            busState_next = ST_IDLE;
         end
         default: begin
            busState_next = ST_IDLE;
         end
      endcase
   end

   // =====================================================================
   // address phase capture
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         busState_reg <= ST_IDLE;
         addr_reg     <= {(`DSG_ADDR_MSB+1){1'b0}};
         isWrite_reg  <= 1'b0;
         isWord_reg   <= 1'b0;
      end else begin
         busState_reg <= busState_next;
         if (addrPhase && (busState_reg == ST_IDLE)) begin
            addr_reg    <= haddr[`DSG_ADDR_MSB:0];
            isWrite_reg <= hwrite;
            // only whole-word transfers touch the registers
            isWord_reg  <= (hsize == `DSG_HSIZE_WORD);
         end
      end
   end

   // =====================================================================
   // register write decode
   // reserved bits are masked off so they can never be stored
   always @* begin
      deepGate_next = deepGate_reg;
      intMask_next  = intMask_reg;
      statusClear   = {NUM_UNITS{1'b0}};
      if (dataWrite) begin
         case (addr_reg)
            `DSG_ADDR_DEEP: begin
               deepGate_next = hwdata & `DSG_DEEP_WMASK;
            end
            `DSG_ADDR_ISTAT: begin
               statusClear = hwdata[NUM_UNITS-1:0];
            end
            `DSG_ADDR_IMASK: begin
               intMask_next = hwdata[NUM_UNITS-1:0];
            end
            default: begin
               // unmapped writes are dropped, still answered okay
               deepGate_next = deepGate_reg;
            end
         endcase
      end
   end

   // =====================================================================
   // sticky status, a new event wins over a clear in the same cycle
   always @* begin
      intStatus_next = (intStatus_reg & ~statusClear) | gatedHit;
   end

   // =====================================================================
   // read data mux, unmapped addresses read as zero
   always @* begin
      rdData_next = 32'h00000000;
      if (dataRead) begin
         case (addr_reg)
            `DSG_ADDR_DEEP: begin
               rdData_next = deepGate_reg & `DSG_DEEP_WMASK;
            end
            `DSG_ADDR_ISTAT: begin
               rdData_next[NUM_UNITS-1:0] = intStatus_reg;
            end
            `DSG_ADDR_IMASK: begin
               rdData_next[NUM_UNITS-1:0] = intMask_reg;
            end
            default: begin
               rdData_next = 32'h00000000;
            end
         endcase
      end
   end

   // =====================================================================
   // register storage
   // the deep-sleep bank wakes with the hibernation unit clocked
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         deepGate_reg  <= `DSG_DEEP_RESET;
         intStatus_reg <= {NUM_UNITS{1'b0}};
         intMask_reg   <= {NUM_UNITS{1'b0}};
      end else begin
         deepGate_reg  <= deepGate_next;
         intStatus_reg <= intStatus_next;
         intMask_reg   <= intMask_next;
      end
   end

   // =====================================================================
   // bus answer flip-flops
   // hreadyout drops for the one wait state after each capture
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= `DSG_HRESP_OKAY;
      end else begin
         hresp <= `DSG_HRESP_OKAY;
         if (busState_reg == ST_DATA) begin
            hrdata    <= rdData_next;
            hreadyout <= 1'b1;
         end else if (addrPhase) begin
            hreadyout <= 1'b0;
         end
      end
   end

   // =====================================================================
   // deep-sleep enables per unit, from their own register bits
   always @* begin
      deepEn = {NUM_UNITS{1'b0}};
      deepEn[`DSG_UNIT_CONV] = deepGate_reg[`DSG_BIT_CONV];
      deepEn[`DSG_UNIT_HIB]  = deepGate_reg[`DSG_BIT_HIB];
      deepEn[`DSG_UNIT_WDOG] = deepGate_reg[`DSG_BIT_WDOG];
   end

   // =====================================================================
   // one gate per unit; hibernation never raises a bus fault
   genvar u;
   generate
      for (u = 0; u < NUM_UNITS; u = u + 1) begin : g_unit
         dsg_unit_gate #(
            .CAN_FAULT (((`DSG_FAULT_UNITS >> u) & 3'h1) != 3'h0)
         ) u_gate (
            .core_clk         (core_clk),
            .arst_n           (arst_n),
            .runEn            (runGateEn[u]),
            .sleepEn          (sleepGateEn[u]),
            .deepEn           (deepEn[u]),
            .autoGatingSelect (autoGatingSelect),
            .powerState       (powerState),
            .unitAccess       (unitAccess[u]),
            .clkEn_reg        (unitClkEn[u]),
            .accessFault_reg  (unitFault[u]),
            .gatedHit_reg     (gatedHit[u])
         );
      end
   endgenerate

   // =====================================================================
   // converter sample speed in force for the present power state
   // no range check here: staying within the part maximum is software's job
   always @* begin
      sampleSpeed_next = runSampleSpeed;
      if (autoGatingSelect && (powerState == `DSG_PWR_SLEEP)) begin
         sampleSpeed_next = sleepSampleSpeed;
      end else if (autoGatingSelect && (powerState == `DSG_PWR_DEEP)) begin
         sampleSpeed_next = deepGate_reg[`DSG_SPEED_MSB:`DSG_SPEED_LSB];
      end
   end

   // =====================================================================
   // speed output and interrupt line, both registered
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sampleSpeed <= `DSG_SPEED_125K;
         irq         <= 1'b0;
      end else begin
         sampleSpeed <= sampleSpeed_next;
         // follows the stored status, so it drops one cycle after a clear
         irq         <= |(intStatus_reg & intMask_reg);
      end
   end

endmodule // dsg_clock_gate_ctrl

// [sim/dsg_clock_gate_props.sv]
// concurrent checks on the ports of the gating control block
`include "dsg_defs.vh"
module dsg_clock_gate_props #(
   parameter NUM_UNITS = 3
) (
   input logic                 core_clk,
   input logic                 arst_n,
   input logic                 hsel,
   input logic [1:0]           htrans,
   input logic                 hready,
   input logic                 hreadyout,
   input logic                 hresp,
   input logic [NUM_UNITS-1:0] runGateEn,
   input logic [NUM_UNITS-1:0] sleepGateEn,
   input logic                 autoGatingSelect,
   input logic [1:0]           powerState,
   input logic [1:0]           runSampleSpeed,
   input logic [1:0]           sleepSampleSpeed,
   input logic [1:0]           sampleSpeed,
   input logic [NUM_UNITS-1:0] unitAccess,
   input logic [NUM_UNITS-1:0] unitClkEn,
   input logic [NUM_UNITS-1:0] unitFault
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // =====================================================================
   // bank selection seen from the power state inputs
   logic sleepSel;
   logic runSel;
   assign sleepSel = autoGatingSelect && powerState == `DSG_PWR_SLEEP;
   assign runSel = !autoGatingSelect || !(sleepSel || powerState == `DSG_PWR_DEEP);
   conv_fault_a:
      assert property (unitAccess[0] && !unitClkEn[0] |=> unitFault[0])
      else $error("gated converter access gave no fault");
   wdog_fault_a:
      assert property (unitAccess[2] && !unitClkEn[2] |=> unitFault[2])
      else $error("gated watchdog access gave no fault");
   wdog_cause_a:
      assert property (unitFault[2] |-> $past(unitAccess[2] && !unitClkEn[2]))
      else $error("watchdog fault without gated access");
   hib_nofault_a:
      assert property (!unitFault[1])
      else $error("hibernation unit faulted");
   run_select_a:
      assert property (runSel |=> unitClkEn == $past(runGateEn))
      else $error("run enables not in force");
   sleep_select_a:
      assert property (sleepSel |=> unitClkEn == $past(sleepGateEn))
      else $error("sleep enables not in force");
   run_speed_a:
      assert property (runSel |=> sampleSpeed == $past(runSampleSpeed))
      else $error("run speed not in force");
   sleep_speed_a:
      assert property (sleepSel |=> sampleSpeed == $past(sleepSampleSpeed))
      else $error("sleep speed not in force");
   one_wait_a:
      assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
      else $error("bus transfer not one wait state");
   bus_okay_a:
      assert property (hresp == `DSG_HRESP_OKAY)
      else $error("bus response not okay");
endmodule // dsg_clock_gate_props

bind dsg_clock_gate_ctrl dsg_clock_gate_props #(
   .NUM_UNITS (NUM_UNITS)
) chk (
   .core_clk         (core_clk),
   .arst_n           (arst_n),
   .hsel             (hsel),
   .htrans           (htrans),
   .hready           (hready),
   .hreadyout        (hreadyout),
   .hresp            (hresp),
   .runGateEn        (runGateEn),
   .sleepGateEn      (sleepGateEn),
   .autoGatingSelect (autoGatingSelect),
   .powerState       (powerState),
   .runSampleSpeed   (runSampleSpeed),
   .sleepSampleSpeed (sleepSampleSpeed),
   .sampleSpeed      (sampleSpeed),
   .unitAccess       (unitAccess),
   .unitClkEn        (unitClkEn),
   .unitFault        (unitFault)
);

// [sim/dsg_unit_model.sv]
// far-side unit model: issues unit accesses and counts the faults drawn
module dsg_unit_model (
   input  logic       core_clk,
   input  logic       arst_n,
   input  logic [2:0] kick,
   input  logic [2:0] unitFault,
   output logic [2:0] unitAccess,
   output logic [7:0] faultCnt
);
   timeunit 1ns;
   timeprecision 100ps;
   // one access beat per kick; faults counted so lost pulses show up
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         unitAccess <= 3'h0;
         faultCnt <= 8'h00;
      end else begin
         unitAccess <= kick;
         faultCnt <= faultCnt + unitFault[0] + unitFault[1] + unitFault[2];
      end
   end
endmodule // dsg_unit_model

// [sim/dsg_clock_gate_ctrl_bench.sv]
// self-checking bench for the deep-sleep gating control block
`include "dsg_defs.vh"
module dsg_clock_gate_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk = 0, arst_n = 0, hsel = 0, hwrite = 0, autoSel = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0]  htrans = 0, powerState = 0, runSpd = 0, sleepSpd = 2'h1, sampleSpeed;
   logic [2:0]  hsize = 0, runEn = 3'h5, sleepEn = 3'h3, kick = 0, busSize = `DSG_HSIZE_WORD;
   logic [2:0]  unitAccess, unitClkEn, unitFault;
   logic        hreadyout, hresp, irq;
   logic [7:0]  faultCnt;
   int          err_total = 0, num_checks = 0, cyc = 0;
   initial forever #12.5 core_clk = ~core_clk;
   dsg_clock_gate_ctrl DUT (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .runGateEn(runEn), .sleepGateEn(sleepEn), .autoGatingSelect(autoSel),
      .powerState(powerState), .runSampleSpeed(runSpd), .sleepSampleSpeed(sleepSpd),
      .unitAccess(unitAccess), .unitClkEn(unitClkEn), .unitFault(unitFault),
      .sampleSpeed(sampleSpeed), .irq(irq));
   dsg_unit_model unitSide (.core_clk(core_clk), .arst_n(arst_n), .kick(kick),
      .unitFault(unitFault), .unitAccess(unitAccess), .faultCnt(faultCnt));
   // =====================================================================
   // reporting
   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // a hang ends the run as a mismatch
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         finish_test;
      end
   end
   // =====================================================================
   // bus and unit tasks; address held until hready is seen high
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      hsize <= busSize;
      @(posedge core_clk iff hreadyout === 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge core_clk iff hreadyout === 1'b1);
      q = hrdata;
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk("read", q, exp);
   endtask
   task automatic gchk(input logic [2:0] exp);
      repeat (2) @(posedge core_clk);
      chk("unitClkEn", unitClkEn, exp);
   endtask
   task automatic hit(input logic [2:0] m);
      kick <= m;
      @(posedge core_clk);
      kick <= 3'h0;
      repeat (4) @(posedge core_clk);
   endtask
   // =====================================================================
   // main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      rchk(`DSG_ADDR_DEEP, `DSG_DEEP_RESET);
      rchk(`DSG_ADDR_ISTAT, 32'h0);
      gchk(3'h5);
      bus(1'b1, `DSG_ADDR_DEEP, 32'hfffffcff);
      rchk(`DSG_ADDR_DEEP, 32'h00010048);
      powerState <= `DSG_PWR_DEEP;
      autoSel <= 1'b1;
      gchk(3'h7);
      // read-modify-write keeps reserved bits and a legal speed
      bus(1'b0, `DSG_ADDR_DEEP, 32'h0);
      bus(1'b1, `DSG_ADDR_DEEP, (q & ~32'h300) | 32'h100);
      @(posedge core_clk);
      chk("speed", sampleSpeed, `DSG_SPEED_250K);
      bus(1'b1, `DSG_ADDR_DEEP, 32'h0);
      gchk(3'h0);
      chk("speed", sampleSpeed, `DSG_SPEED_125K);
      bus(1'b1, `DSG_ADDR_IMASK, 32'h7);
      hit(3'h7);
      chk("faults", faultCnt, 32'h2);
      chk("irq", irq, 32'h1);
      rchk(`DSG_ADDR_ISTAT, 32'h7);
      bus(1'b1, `DSG_ADDR_ISTAT, 32'h7);
      rchk(`DSG_ADDR_ISTAT, 32'h0);
      chk("irq", irq, 32'h0);
      bus(1'b1, `DSG_ADDR_IMASK, 32'h0);
      hit(3'h4);
      chk("irq", irq, 32'h0);
      bus(1'b1, `DSG_ADDR_IMASK, 32'h4);
      @(posedge core_clk);
      chk("irq", irq, 32'h1);
      bus(1'b1, `DSG_ADDR_ISTAT, 32'h4);
      // software enables the units it needs
      bus(1'b1, `DSG_ADDR_DEEP, 32'h00000048);
      gchk(3'h6);
      hit(3'h4);
      chk("faults", faultCnt, 32'h3);
      // a byte-sized write must leave the register untouched
      busSize = 3'h0;
      bus(1'b1, `DSG_ADDR_DEEP, 32'h0);
      busSize = `DSG_HSIZE_WORD;
      rchk(`DSG_ADDR_DEEP, 32'h00000048);
      powerState <= `DSG_PWR_SLEEP;
      gchk(sleepEn);
      chk("speed", sampleSpeed, sleepSpd);
      autoSel <= 1'b0;
      powerState <= `DSG_PWR_DEEP;
      gchk(runEn);
      chk("speed", sampleSpeed, runSpd);
      // the unused power state code falls back to the run bank
      autoSel <= 1'b1;
      powerState <= 2'h3;
      gchk(runEn);
      chk("speed", sampleSpeed, runSpd);
      rchk(32'h200, 32'h0);
      // second reset in mid-run
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      rchk(`DSG_ADDR_DEEP, `DSG_DEEP_RESET);
      finish_test;
   end
endmodule // dsg_clock_gate_ctrl_bench
